// ===== src/bolatch_pkg.sv
// constants shared by the binary input/output conditioning block
package bolatch_pkg;

    // register byte offsets, global words
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_ACK        = 8'h04;
    localparam logic [7:0] REG_DI_STATUS  = 8'h08;
    localparam logic [7:0] REG_BO_STATUS  = 8'h0c;
    localparam logic [7:0] REG_LATCHED    = 8'h10;
    localparam logic [7:0] REG_SYS_STATUS = 8'h14;

    // per-input window: base + 4 * input index
    localparam logic [7:0] DI_BASE        = 8'h40;
    localparam logic [7:0] DI_LIMIT       = 8'h80;
    // per-output window: base + 16 * output index + 4 * word
    localparam logic [7:0] BO_BASE        = 8'h80;
    localparam int         BO_STRIDE_LOG2 = 4;
    localparam logic [1:0] BO_W_SEL_LO    = 2'h0;
    localparam logic [1:0] BO_W_SEL_HI    = 2'h1;
    localparam logic [1:0] BO_W_CFG       = 2'h2;
    localparam logic [1:0] BO_W_TIME      = 2'h3;

    // field positions
    localparam int CTRL_REMOTE_EN_BIT = 0;
    localparam int ACK_PANEL_BIT      = 0;
    localparam int ACK_SCADA_BIT      = 1;
    localparam int DI_INV_BIT         = 16;
    localparam int CFG_CINV_BIT       = 8;
    localparam int CFG_CLOSED_BIT     = 9;
    localparam int CFG_LATCH_BIT      = 10;
    localparam int CFG_ACKSEL_LSB     = 16;
    localparam int TIME_RET_LSB       = 16;

    // structure
    localparam int NUM_SLOTS = 7;
    localparam int SEL_W     = 8;
    localparam int TIME_W    = 16;

    // values after reset
    localparam logic [TIME_W-1:0] DEB_RST    = 16'h0000;
    localparam logic [TIME_W-1:0] HOLD_RST   = 16'h0000;
    localparam logic [TIME_W-1:0] RET_RST    = 16'h0000;
    localparam logic [SEL_W-1:0]  SEL_NONE   = 8'h00;

    // led flash timing
    localparam int CLK_HZ           = 50_000_000;
    localparam int FLASH_HALF_MS    = 500;
    localparam int FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;

endpackage

// ===== src/bolatch_top.sv
// binary input debounce, output relay trigger logic, latching, life contact and status led
// Notes on behaviour
// - input change passes at once, timer starts
// - filtered state frozen while debounce timer runs
// - optional inversion of each debounced input
// - seven selectable triggers OR-combined per output
// - per-trigger inversion before the OR
// - unassigned slot always contributes zero
// - optional collective inversion of combined state
// - no slot assigned: state zero, no inversion
// - working-current or closed-circuit drive per output
// - unlatched contact follows collective state
// - latched output held until valid clear
// - clear needs triggers dropped plus acknowledge source
// - all slots unassigned clears latch
// - ack accepted only after retention delay
// - contact holds each new state minimum hold time
// - latched states survive warm restart (boot_done low), cleared by rst_n
// - global ack clears all latched outputs
// - global ack honoured only with remote enable
// - life contact off in boot, on when healthy
// - status led flashes in boot, steady when active
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps

module bolatch_top #(
    parameter int NUM_DI            = 8,
    parameter int NUM_BO            = 8,
    parameter int NUM_SIG           = 32,
    parameter int FLASH_HALF_CYCLES = bolatch_pkg::FLASH_HALF_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [7:0]            addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [31:0]           rdata,
    input  wire logic [NUM_DI-1:0]     di_raw,
    input  wire logic [NUM_SIG-1:0]    trig_in,
    input  wire logic                  ack_all_outputs_signal,
    input  wire logic                  boot_done,
    input  wire logic                  internal_fault,
    output logic      [NUM_DI-1:0]     di_state,
    output logic      [NUM_BO-1:0]     relay_coil,
    output logic                       life_contact,
    output logic                       led_green
);

    localparam int POOL_W = NUM_SIG + NUM_DI;
    localparam int TW     = bolatch_pkg::TIME_W;
    localparam int SW     = bolatch_pkg::SEL_W;
    localparam int NS     = bolatch_pkg::NUM_SLOTS;

    typedef struct packed {
        logic                            remote_en;
        logic                            ack_panel;
        logic                            ack_scada;
        logic [31:0]                     rdata;
        logic [NUM_DI-1:0][TW-1:0]       di_deb;
        logic [NUM_DI-1:0]               di_inv;
        logic [NUM_DI-1:0]               di_filt;
        logic [NUM_DI-1:0][TW-1:0]       di_cnt;
        logic [NUM_DI-1:0]               di_q;
        logic [NUM_BO-1:0][NS-1:0][SW-1:0] bo_sel;
        logic [NUM_BO-1:0][NS-1:0]       bo_slot_inv;
        logic [NUM_BO-1:0]               bo_cinv;
        logic [NUM_BO-1:0]               bo_closed;
        logic [NUM_BO-1:0]               bo_latch_en;
        logic [NUM_BO-1:0][SW-1:0]       bo_ack_sel;
        logic [NUM_BO-1:0][TW-1:0]       bo_hold;
        logic [NUM_BO-1:0][TW-1:0]       bo_ret;
        logic [NUM_BO-1:0]               bo_latched;
        logic [NUM_BO-1:0]               bo_contact;
        logic [NUM_BO-1:0][TW-1:0]       bo_hold_cnt;
        logic [NUM_BO-1:0][TW-1:0]       bo_ret_cnt;
        logic [NUM_BO-1:0]               relay_coil;
        logic                            life_contact;
        logic                            led_green;
        logic [31:0]                     blink_cnt;
        logic                            blink_ph;
    } bolatch_state_t;

    bolatch_state_t state_reg;
    bolatch_state_t state_next;

    // selector 0 means unassigned; out-of-range codes read as zero too
    function automatic logic pick(input logic [POOL_W-1:0] pool, input logic [SW-1:0] sel);
        logic r;
        r = 1'b0;
        if (sel != bolatch_pkg::SEL_NONE && int'(sel) <= POOL_W) begin
            r = pool[int'(sel) - 1];
        end
        return r;
    endfunction

    function automatic logic [TW-1:0] dec(input logic [TW-1:0] v);
        return (v == '0) ? v : TW'(v - 1'b1);
    endfunction

    always_comb begin
        logic [POOL_W-1:0] pool;
        logic              asg;
        logic              orv;
        logic              coll;
        logic              ack;
        logic              gack;
        logic              want;
        logic              sel_bit;
        int                oi;
        int                di;
        pool    = '0;
        asg     = 1'b0;
        orv     = 1'b0;
        coll    = 1'b0;
        ack     = 1'b0;
        gack    = 1'b0;
        want    = 1'b0;
        sel_bit = 1'b0;
        oi      = 0;
        di      = 0;
        state_next = state_reg;
        state_next.rdata     = '0;
        state_next.ack_panel = 1'b0;
        state_next.ack_scada = 1'b0;

        // debounce: first edge passes immediately, later edges wait out the timer
        for (int i = 0; i < NUM_DI; i++) begin
            if (state_reg.di_cnt[i] == '0) begin
                if (di_raw[i] != state_reg.di_filt[i]) begin
                    state_next.di_filt[i] = di_raw[i];
                    state_next.di_cnt[i]  = state_reg.di_deb[i];
                end
            end else begin
                state_next.di_cnt[i] = dec(state_reg.di_cnt[i]);
            end
            state_next.di_q[i] = state_next.di_filt[i] ^ state_reg.di_inv[i];
        end

        // debounced inputs are selectable as triggers after the external signals
        pool = {state_reg.di_q, trig_in};

        // global acknowledge only while remote reset is enabled
        gack = state_reg.remote_en
             & (ack_all_outputs_signal | state_reg.ack_scada);

        for (int o = 0; o < NUM_BO; o++) begin
            asg = 1'b0;
            orv = 1'b0;
            for (int k = 0; k < NS; k++) begin
                if (state_reg.bo_sel[o][k] != bolatch_pkg::SEL_NONE) begin
                    asg = 1'b1;
                    orv = orv | (pick(pool, state_reg.bo_sel[o][k])
                               ^ state_reg.bo_slot_inv[o][k]);
                end
            end
            coll = asg & (orv ^ state_reg.bo_cinv[o]);

            // retention delay restarts while any trigger is still up
            if (orv) begin
                state_next.bo_ret_cnt[o] = state_reg.bo_ret[o];
            end else begin
                state_next.bo_ret_cnt[o] = dec(state_reg.bo_ret_cnt[o]);
            end

            sel_bit = pick(pool, state_reg.bo_ack_sel[o]);
            ack     = state_reg.ack_panel | gack | sel_bit;
            if (!asg || !state_reg.bo_latch_en[o]) begin
                state_next.bo_latched[o] = 1'b0;
            end else if (coll) begin
                state_next.bo_latched[o] = 1'b1;
            end else if (state_reg.bo_latched[o] && !orv
                         && state_reg.bo_ret_cnt[o] == '0 && ack) begin
                state_next.bo_latched[o] = 1'b0;
            end

            // latched state is kept while boot_done is low; reset, acknowledge, unassignment or latch disable clear it
            want = coll | (state_reg.bo_latch_en[o] & state_reg.bo_latched[o]);

            if (state_reg.bo_hold_cnt[o] != '0) begin
                state_next.bo_hold_cnt[o] = dec(state_reg.bo_hold_cnt[o]);
            end else if (want != state_reg.bo_contact[o]) begin
                state_next.bo_contact[o]  = want;
                state_next.bo_hold_cnt[o] = state_reg.bo_hold[o];
            end
            state_next.relay_coil[o] = state_next.bo_contact[o]
                                     ^ state_reg.bo_closed[o];
        end

        // life contact and status led
        state_next.life_contact = boot_done & ~internal_fault;
        if (state_reg.blink_cnt >= 32'(FLASH_HALF_CYCLES - 1)) begin
            state_next.blink_cnt = '0;
            state_next.blink_ph  = ~state_reg.blink_ph;
        end else begin
            state_next.blink_cnt = state_reg.blink_cnt + 32'h0000_0001;
        end
        if (!boot_done) begin
            state_next.led_green = state_reg.blink_ph;
        end else begin
            state_next.led_green = ~internal_fault;
        end

        // register writes
        if (wr_en) begin
            if (addr == bolatch_pkg::REG_CTRL) begin
                state_next.remote_en = wdata[bolatch_pkg::CTRL_REMOTE_EN_BIT];
            end else if (addr == bolatch_pkg::REG_ACK) begin
                state_next.ack_panel = wdata[bolatch_pkg::ACK_PANEL_BIT];
                state_next.ack_scada = wdata[bolatch_pkg::ACK_SCADA_BIT];
            end else if (addr >= bolatch_pkg::DI_BASE && addr < bolatch_pkg::DI_LIMIT) begin
                di = int'(addr[5:2]);
                if (di < NUM_DI) begin
                    state_next.di_deb[di] = wdata[TW-1:0];
                    state_next.di_inv[di] = wdata[bolatch_pkg::DI_INV_BIT];
                end
            end else if (addr >= bolatch_pkg::BO_BASE) begin
                oi = int'(addr[6:bolatch_pkg::BO_STRIDE_LOG2]);
                if (oi < NUM_BO) begin
                    case (addr[3:2])
                        bolatch_pkg::BO_W_SEL_LO: begin
                            for (int k = 0; k < 4; k++) begin
                                state_next.bo_sel[oi][k] = wdata[k*SW +: SW];
                            end
                        end
                        bolatch_pkg::BO_W_SEL_HI: begin
                            for (int k = 4; k < NS; k++) begin
                                state_next.bo_sel[oi][k] = wdata[(k-4)*SW +: SW];
                            end
                        end
                        bolatch_pkg::BO_W_CFG: begin
                            state_next.bo_slot_inv[oi] = wdata[NS-1:0];
                            state_next.bo_cinv[oi]     = wdata[bolatch_pkg::CFG_CINV_BIT];
                            state_next.bo_closed[oi]   = wdata[bolatch_pkg::CFG_CLOSED_BIT];
                            state_next.bo_latch_en[oi] = wdata[bolatch_pkg::CFG_LATCH_BIT];
                            state_next.bo_ack_sel[oi]  =
                                wdata[bolatch_pkg::CFG_ACKSEL_LSB +: SW];
                        end
                        bolatch_pkg::BO_W_TIME: begin
                            state_next.bo_hold[oi] = wdata[TW-1:0];
                            state_next.bo_ret[oi]  = wdata[bolatch_pkg::TIME_RET_LSB +: TW];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // register reads, answered in the next cycle; unmapped reads as zero
        if (rd_en) begin
            if (addr == bolatch_pkg::REG_CTRL) begin
                state_next.rdata[bolatch_pkg::CTRL_REMOTE_EN_BIT] = state_reg.remote_en;
            end else if (addr == bolatch_pkg::REG_DI_STATUS) begin
                state_next.rdata[NUM_DI-1:0] = state_reg.di_q;
            end else if (addr == bolatch_pkg::REG_BO_STATUS) begin
                state_next.rdata[NUM_BO-1:0] = state_reg.bo_contact;
            end else if (addr == bolatch_pkg::REG_LATCHED) begin
                state_next.rdata[NUM_BO-1:0] = state_reg.bo_latched;
            end else if (addr == bolatch_pkg::REG_SYS_STATUS) begin
                state_next.rdata[0] = state_reg.life_contact;
                state_next.rdata[1] = state_reg.led_green;
            end else if (addr >= bolatch_pkg::DI_BASE && addr < bolatch_pkg::DI_LIMIT) begin
                di = int'(addr[5:2]);
                if (di < NUM_DI) begin
                    state_next.rdata[TW-1:0] = state_reg.di_deb[di];
                    state_next.rdata[bolatch_pkg::DI_INV_BIT] = state_reg.di_inv[di];
                end
            end else if (addr >= bolatch_pkg::BO_BASE) begin
                oi = int'(addr[6:bolatch_pkg::BO_STRIDE_LOG2]);
                if (oi < NUM_BO) begin
                    case (addr[3:2])
                        bolatch_pkg::BO_W_SEL_LO: begin
                            for (int k = 0; k < 4; k++) begin
                                state_next.rdata[k*SW +: SW] = state_reg.bo_sel[oi][k];
                            end
                        end
                        bolatch_pkg::BO_W_SEL_HI: begin
                            for (int k = 4; k < NS; k++) begin
                                state_next.rdata[(k-4)*SW +: SW] = state_reg.bo_sel[oi][k];
                            end
                        end
                        bolatch_pkg::BO_W_CFG: begin
                            state_next.rdata[NS-1:0] = state_reg.bo_slot_inv[oi];
                            state_next.rdata[bolatch_pkg::CFG_CINV_BIT]   = state_reg.bo_cinv[oi];
                            state_next.rdata[bolatch_pkg::CFG_CLOSED_BIT] = state_reg.bo_closed[oi];
                            state_next.rdata[bolatch_pkg::CFG_LATCH_BIT]  =
                                state_reg.bo_latch_en[oi];
                            state_next.rdata[bolatch_pkg::CFG_ACKSEL_LSB +: SW] =
                                state_reg.bo_ack_sel[oi];
                        end
                        bolatch_pkg::BO_W_TIME: begin
                            state_next.rdata[TW-1:0] = state_reg.bo_hold[oi];
                            state_next.rdata[bolatch_pkg::TIME_RET_LSB +: TW] =
                                state_reg.bo_ret[oi];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // all reset values are zero, matching the package defaults
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata        = state_reg.rdata;
    assign di_state     = state_reg.di_q;
    assign relay_coil   = state_reg.relay_coil;
    assign life_contact = state_reg.life_contact;
    assign led_green    = state_reg.led_green;

endmodule

// ===== testbench/bolatch_properties.sv
// concurrent checks on the ports of the conditioning block
`timescale 1ns/1ps
module bolatch_properties #(
    parameter int NUM_DI            = 8,
    parameter int NUM_BO            = 8,
    parameter int NUM_SIG           = 32,
    parameter int FLASH_HALF_CYCLES = 4
) (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic [7:0]         addr,
    input wire logic [31:0]        wdata,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire logic [31:0]        rdata,
    input wire logic [NUM_DI-1:0]  di_raw,
    input wire logic [NUM_SIG-1:0] trig_in,
    input wire logic               ack_all_outputs_signal,
    input wire logic               boot_done,
    input wire logic               internal_fault,
    input wire logic [NUM_DI-1:0]  di_state,
    input wire logic [NUM_BO-1:0]  relay_coil,
    input wire logic               life_contact,
    input wire logic               led_green
);
    // sticky: once config is written the default-config checks stand down
    logic di_cfg_reg;
    logic bo_cfg_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            di_cfg_reg <= 1'b0;
            bo_cfg_reg <= 1'b0;
        end else if (wr_en) begin
            if (addr >= bolatch_pkg::DI_BASE && addr < bolatch_pkg::DI_LIMIT) begin
                di_cfg_reg <= 1'b1;
            end
            if (addr >= bolatch_pkg::BO_BASE) begin
                bo_cfg_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property ($past(rst_n) && !$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_ack_reads_zero: assert property (
        $past(rd_en) && $past(addr) == bolatch_pkg::REG_ACK |-> rdata == 32'h0)
        else $error("acknowledge word did not read zero");
    a_di_readback: assert property (
        $past(rd_en) && $past(addr) == bolatch_pkg::REG_DI_STATUS
        |-> rdata[NUM_DI-1:0] == $past(di_state))
        else $error("input status word differs from input outputs");
    a_sys_readback: assert property (
        $past(rd_en) && $past(addr) == bolatch_pkg::REG_SYS_STATUS
        |-> rdata[1:0] == {$past(led_green), $past(life_contact)})
        else $error("system status word differs from outputs");
    a_di_follow: assert property (
        $past(rst_n) && !di_cfg_reg |-> di_state == $past(di_raw))
        else $error("input did not pass through at once");
    a_bo_unassigned: assert property (!bo_cfg_reg |-> relay_coil == '0)
        else $error("unassigned output drove its coil");
    a_life_follow: assert property (
        $past(rst_n) |-> life_contact == ($past(boot_done) && !$past(internal_fault)))
        else $error("life contact wrong for boot and fault state");
    a_led_steady: assert property (
        $past(rst_n) && $past(boot_done) |-> led_green == !$past(internal_fault))
        else $error("status led not steady after boot");
    a_led_flash: assert property (
        (!boot_done) [*8] |-> led_green != $past(led_green, 4))
        else $error("status led not flashing during boot");
endmodule

// ===== testbench/bolatch_partner.sv
// far side: protection trigger sources and global acknowledge
`timescale 1ns/1ps
module bolatch_partner (
    input  wire logic        sys_clk,
    input  wire logic [31:0] trig_cmd,
    input  wire logic        ack_cmd,
    output logic      [31:0] trig_in,
    output logic             ack_all_outputs_signal
);
    initial begin
        trig_in = 32'h0;
        ack_all_outputs_signal = 1'b0;
    end
    // sources move just after the edge, as registered protection logic would
    always @(posedge sys_clk) begin
        trig_in <= trig_cmd;
        ack_all_outputs_signal <= ack_cmd;
    end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the binary input/output conditioning block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    typedef struct packed {
        logic [2:0]  slot;
        logic [7:0]  sel;
        logic        inv;
        logic [1:0]  cfg;
        logic [31:0] trig;
        logic        exp;
    } bolatch_row_t;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   addr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    logic [31:0]  rdata;
    logic [7:0]   di_raw = 8'h00;
    logic [31:0]  trig_in;
    logic [31:0]  trig_cmd = 32'h0;
    logic         ack_cmd = 1'b0;
    logic         ack_all_outputs_signal;
    logic         boot_done = 1'b0;
    logic         internal_fault = 1'b0;
    logic [7:0]   di_state;
    logic [7:0]   relay_coil;
    logic         life_contact;
    logic         led_green;
    int           errors = 0;
    int           total_checks = 0;
    int           cycles = 0;
    bolatch_row_t r;
    // slot, select code, slot invert, {closed, collective invert}, triggers, coil
    bolatch_row_t rows [9] = '{
        '{3'd0, 8'h01, 1'b0, 2'h0, 32'h1, 1'b1},
        '{3'd6, 8'h20, 1'b0, 2'h0, 32'h8000_0000, 1'b1},
        '{3'd3, 8'h01, 1'b1, 2'h0, 32'h0, 1'b1},
        '{3'd2, 8'h00, 1'b1, 2'h1, 32'h0, 1'b0},
        '{3'd0, 8'h01, 1'b0, 2'h1, 32'h0, 1'b1},
        '{3'd1, 8'h21, 1'b0, 2'h0, 32'h0, 1'b1},
        '{3'd4, 8'h30, 1'b0, 2'h1, 32'h0, 1'b1},
        '{3'd0, 8'h01, 1'b0, 2'h2, 32'h1, 1'b0},
        '{3'd5, 8'h01, 1'b0, 2'h2, 32'h0, 1'b1}};

    bolatch_top #(.FLASH_HALF_CYCLES(4)) bolatch_top_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .di_raw(di_raw), .trig_in(trig_in),
        .ack_all_outputs_signal(ack_all_outputs_signal), .boot_done(boot_done),
        .internal_fault(internal_fault), .di_state(di_state), .relay_coil(relay_coil),
        .life_contact(life_contact), .led_green(led_green));
    bolatch_partner bolatch_partner_inst (
        .sys_clk(sys_clk), .trig_cmd(trig_cmd), .ack_cmd(ack_cmd), .trig_in(trig_in),
        .ack_all_outputs_signal(ack_all_outputs_signal));

    always #10 sys_clk = ~sys_clk;

    task conclude();
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        `CHK(life_contact, 1'b0)
        rd(bolatch_pkg::REG_CTRL, 32'h0);
        rd(8'h40, 32'(bolatch_pkg::DEB_RST));
        rd(8'h8c, {bolatch_pkg::RET_RST, bolatch_pkg::HOLD_RST});
        rd(8'h20, 32'h0);
        rd(bolatch_pkg::REG_ACK, 32'h0);
        di_raw <= 8'ha5;
        tick(1);
        `CHK(di_state, 8'ha5)
        boot_done <= 1'b1;
        wr(8'h40, 32'd10);
        di_raw <= 8'ha4;
        tick(1);
        `CHK(di_state[0], 1'b0)
        di_raw <= 8'ha5;
        tick(4);
        `CHK(di_state[0], 1'b0)
        tick(12);
        `CHK(di_state[0], 1'b1)
        wr(8'h44, 32'h0001_0000);
        tick(1);
        `CHK(di_state[1], 1'b1)
        rd(bolatch_pkg::REG_DI_STATUS, 32'h0000_00a7);
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'h80, r.slot < 4 ? 32'(r.sel) << (8 * r.slot) : 32'h0);
            wr(8'h84, r.slot >= 4 ? 32'(r.sel) << (8 * (r.slot - 4)) : 32'h0);
            wr(8'h88, (32'(r.inv) << r.slot) | (32'(r.cfg) << 8));
            trig_cmd <= r.trig;
            tick(4);
            `CHK(relay_coil[0], r.exp)
        end
        // output 1 latched on trigger 1, retention of 8 ticks
        wr(8'h90, 32'h2);
        wr(8'h9c, 32'h0008_0000);
        wr(8'h98, 32'h0000_0400);
        trig_cmd <= 32'h2;
        tick(3);
        trig_cmd <= 32'h0;
        wr(bolatch_pkg::REG_ACK, 32'h1);
        tick(4);
        `CHK(relay_coil[1], 1'b1)
        rd(bolatch_pkg::REG_LATCHED, 32'h0000_0002);
        // output 0 is closed-circuit: coil high, contact low
        rd(bolatch_pkg::REG_BO_STATUS, 32'h0000_0002);
        boot_done <= 1'b0;
        tick(3);
        boot_done <= 1'b1;
        tick(8);
        `CHK(relay_coil[1], 1'b1)
        ack_cmd <= 1'b1;
        tick(4);
        ack_cmd <= 1'b0;
        `CHK(relay_coil[1], 1'b1)
        wr(bolatch_pkg::REG_CTRL, 32'h1);
        ack_cmd <= 1'b1;
        tick(4);
        ack_cmd <= 1'b0;
        `CHK(relay_coil[1], 1'b0)
        trig_cmd <= 32'h2;
        tick(3);
        trig_cmd <= 32'h0;
        tick(12);
        wr(bolatch_pkg::REG_ACK, 32'h2);
        tick(4);
        `CHK(relay_coil[1], 1'b0)
        trig_cmd <= 32'h2;
        wr(8'h98, 32'h0003_0400);
        trig_cmd <= 32'h0;
        tick(12);
        trig_cmd <= 32'h4;
        tick(4);
        `CHK(relay_coil[1], 1'b0)
        trig_cmd <= 32'h2;
        tick(3);
        trig_cmd <= 32'h0;
        wr(8'h90, 32'h0);
        tick(4);
        `CHK(relay_coil[1], 1'b0)
        // panel ack after retention, then latching switched off
        wr(8'h90, 32'h2);
        trig_cmd <= 32'h2;
        tick(3);
        trig_cmd <= 32'h0;
        tick(12);
        wr(bolatch_pkg::REG_ACK, 32'h1);
        tick(4);
        `CHK(relay_coil[1], 1'b0)
        trig_cmd <= 32'h2;
        tick(3);
        trig_cmd <= 32'h0;
        wr(8'h98, 32'h0);
        rd(bolatch_pkg::REG_LATCHED, 32'h0);
        // output 2 with a hold of 6 ticks against a two-cycle trigger
        wr(8'hac, 32'h6);
        wr(8'ha0, 32'h1);
        trig_cmd <= 32'h1;
        tick(2);
        trig_cmd <= 32'h0;
        tick(2);
        `CHK(relay_coil[2], 1'b1)
        tick(8);
        `CHK(relay_coil[2], 1'b0)
        internal_fault <= 1'b1;
        tick(2);
        `CHK(life_contact, 1'b0)
        `CHK(led_green, 1'b0)
        internal_fault <= 1'b0;
        tick(2);
        `CHK(life_contact, 1'b1)
        rd(bolatch_pkg::REG_SYS_STATUS, 32'h3);
        conclude();
    end
endmodule

bind bolatch_top bolatch_properties #(
    .NUM_DI(NUM_DI), .NUM_BO(NUM_BO), .NUM_SIG(NUM_SIG),
    .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) bolatch_properties_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .di_raw(di_raw), .trig_in(trig_in),
    .ack_all_outputs_signal(ack_all_outputs_signal), .boot_done(boot_done),
    .internal_fault(internal_fault), .di_state(di_state), .relay_coil(relay_coil),
    .life_contact(life_contact), .led_green(led_green));
